// *** rtl/acs_pkg.sv ***
// acs_pkg: constants and types shared by the conversion sequencer and its timing unit
// assumes a single 40 MHz ref_clk domain with synchronous active-high reset
package acs_pkg;
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned NUM_CH = 8;
	localparam int unsigned CH_W = 3;
	localparam int unsigned RES_W = 10;
	// per-channel conversion lengths in converter clock cycles
	localparam logic [5:0] CYC_8B_PLAIN = 6'd49;
	localparam logic [5:0] CYC_10B_PLAIN = 6'd59;
	localparam logic [5:0] CYC_8B_SH = 6'd28;
	localparam logic [5:0] CYC_10B_SH = 6'd33;
	// converter clock divider select codes
	localparam logic [1:0] DIV_1 = 2'h0;
	localparam logic [1:0] DIV_2 = 2'h1;
	localparam logic [1:0] DIV_4 = 2'h2;
	// operating mode codes
	localparam logic [2:0] MODE_ONE_SHOT = 3'h0;
	localparam logic [2:0] MODE_REPEAT = 3'h1;
	localparam logic [2:0] MODE_SINGLE_SWEEP = 3'h2;
	localparam logic [2:0] MODE_REP_SWEEP0 = 3'h3;
	localparam logic [2:0] MODE_REP_SWEEP1 = 3'h4;
	// sample-and-hold enable sits in bit 0 of the second control byte
	localparam int unsigned SH_BIT = 0;
	// reference ladder connect bit position in its control byte
	localparam int unsigned LADDER_BIT = 5;
	typedef enum logic [1:0] {ACS_IDLE, ACS_CONV, ACS_DONE} acs_state_e;
endpackage : acs_pkg

// *** rtl/acs_tick_if.sv ***
// acs_tick_if: converter clock tick, divider select and run enable between sequencer and timer
// assumes both ends sit on ref_clk
`timescale 1ns/100ps
interface acs_tick_if;
	logic [1:0] div_sel;
	logic run;
	logic tick;
	modport timer
	(
		input div_sel,
		input run,
		output tick
	);
	modport seq
	(
		output div_sel,
		output run,
		input tick
	);
endinterface : acs_tick_if

// *** rtl/acs_tick_gen.sv ***
// acs_tick_gen: divides ref_clk into converter clock ticks (base, /2, /4)
// assumes div_sel is only changed while run is low
`timescale 1ns/100ps
module acs_tick_gen
(
	input wire logic ref_clk,
	input wire logic rst,
	acs_tick_if.timer tk
);
	typedef struct packed
	{
		logic [1:0] cnt;
		logic tick;
	} acs_tg_s;
	acs_tg_s st_r;
	acs_tg_s st_nxt;
	logic [1:0] last;

	always_comb
	begin
		case (tk.div_sel)
			acs_pkg::DIV_2: last = 2'h1;
			acs_pkg::DIV_4: last = 2'h3;
			default: last = 2'h0;
		endcase
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (!tk.run)
		begin
			st_nxt.cnt = 2'h0;
		end
		else if (st_r.cnt >= last)
		begin
			st_nxt.cnt = 2'h0;
			st_nxt.tick = 1'b1;
		end
		else
		begin
			st_nxt.cnt = st_r.cnt + 2'h1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign tk.tick = st_r.tick;

	property p_div4_spacing;
		@(posedge ref_clk) disable iff (rst)
		(st_r.tick && tk.run && tk.div_sel == acs_pkg::DIV_4 && $stable(tk.div_sel)) |=> !st_r.tick [*3];
	endproperty
	a_div4_spacing: assert property (p_div4_spacing) else $error("divide-by-4 tick came too early");
endmodule : acs_tick_gen

// *** rtl/acs_seq.sv ***
// acs_seq: conversion sequencer for an 8-input successive approximation converter
// assumes the comparator core returns a settled result while conv_active ends, held on sar_result
// Notes on behaviour
// - resolution is 8 or 10 bits, chosen before conversion starts
// - each finished conversion is written to the converted channel's result
// - 10-bit: low eight bits to even byte, top two bits to odd byte
// - 8-bit: the whole eight-bit result goes to the even byte
// - five modes exist; only one-shot and repeat are sequenced here
// - software-only trigger: start flag rising from zero to one begins conversion
// - without sample-and-hold: 49 cycles at 8 bits, 59 at 10 bits
// - with sample-and-hold: 28 cycles at 8 bits, 33 at 10 bits
// - converter clock is base, base/2 or base/4
// - one-shot converts the selected channel exactly once per start
// - one-shot clears start flag at finish; writing zero also stops
// - one-shot raises interrupt request at finish
// - repeat converts selected channel until start cleared, no interrupt
// - channel is exactly one of eight inputs via channel select
// - ladder connect bit isolates the reference when clear; set before start
// - sample-and-hold enable bit chosen before starting any mode
`timescale 1ns/100ps
module acs_seq
#(
	parameter int unsigned NUM_CH = acs_pkg::NUM_CH
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic start_wr,
	input wire logic start_wdata,
	input wire logic [2:0] mode,
	input wire logic [2:0] ch_sel,
	input wire logic res_10b,
	input wire logic sh_en,
	input wire logic [1:0] div_sel,
	input wire logic ladder_connect,
	input wire logic [9:0] sar_result,
	output logic start_flag,
	output logic conv_active,
	output logic [2:0] conv_ch,
	output logic ladder_on,
	output logic irq,
	output logic [8*NUM_CH-1:0] res_lo,
	output logic [8*NUM_CH-1:0] res_hi
);
	typedef struct packed
	{
		acs_pkg::acs_state_e state;
		logic start;
		logic active;
		logic [2:0] ch;
		logic res10;
		logic sh;
		logic [1:0] div;
		logic [5:0] left;
		logic ladder;
		logic irq;
		logic [8*NUM_CH-1:0] lo;
		logic [8*NUM_CH-1:0] hi;
	} acs_seq_s;

	acs_seq_s st_r;
	acs_seq_s st_nxt;
	acs_tick_if tk ();

	// conversion length table, read at start and in the checks
	function automatic logic [5:0] conv_len(input logic r10, input logic sh);
		if (sh)
		begin
			conv_len = r10 ? acs_pkg::CYC_10B_SH : acs_pkg::CYC_8B_SH;
		end
		else
		begin
			conv_len = r10 ? acs_pkg::CYC_10B_PLAIN : acs_pkg::CYC_8B_PLAIN;
		end
	endfunction : conv_len

	function automatic logic runnable(input logic [2:0] m);
		runnable = (m == acs_pkg::MODE_ONE_SHOT) || (m == acs_pkg::MODE_REPEAT);
	endfunction : runnable

	acs_tick_gen u_tick
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.tk(tk)
	);

	assign tk.div_sel = st_r.div;
	assign tk.run = st_r.active;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.irq = 1'b0;
		st_nxt.ladder = ladder_connect;
		if (start_wr)
		begin
			st_nxt.start = start_wdata;
		end
		case (st_r.state)
			acs_pkg::ACS_IDLE:
			begin
				// only a 0->1 write with the ladder connected and a sequenced mode starts work
				if (start_wr && start_wdata && !st_r.start && ladder_connect && runnable(mode))
				begin
					st_nxt.state = acs_pkg::ACS_CONV;
					st_nxt.active = 1'b1;
					st_nxt.ch = ch_sel;
					st_nxt.res10 = res_10b;
					st_nxt.sh = sh_en;
					st_nxt.div = div_sel;
					st_nxt.left = conv_len(res_10b, sh_en);
				end
			end
			acs_pkg::ACS_CONV:
			begin
				if (start_wr && !start_wdata)
				begin
					// abandoned: results untouched
					st_nxt.state = acs_pkg::ACS_IDLE;
					st_nxt.active = 1'b0;
				end
				else if (tk.tick)
				begin
					if (st_r.left == 6'd1)
					begin
						st_nxt.state = acs_pkg::ACS_DONE;
						st_nxt.active = 1'b0;
					end
					st_nxt.left = st_r.left - 6'd1;
				end
			end
			acs_pkg::ACS_DONE:
			begin
				st_nxt.lo[8*st_r.ch +: 8] = st_r.res10 ? sar_result[7:0] : sar_result[9:2];
				st_nxt.hi[8*st_r.ch +: 8] = st_r.res10 ? {6'h00, sar_result[9:8]} : 8'h00;
				if (mode == acs_pkg::MODE_REPEAT && !(start_wr && !start_wdata) && st_r.start)
				begin
					// repeat keeps settings, takes the channel from ch_sel again, relaunches at once
					st_nxt.state = acs_pkg::ACS_CONV;
					st_nxt.active = 1'b1;
					st_nxt.ch = ch_sel;
					st_nxt.left = conv_len(st_r.res10, st_r.sh);
				end
				else
				begin
					st_nxt.state = acs_pkg::ACS_IDLE;
					st_nxt.start = 1'b0;
					st_nxt.irq = (mode != acs_pkg::MODE_REPEAT);
				end
			end
			default:
			begin
				st_nxt.state = acs_pkg::ACS_IDLE;
				st_nxt.active = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign start_flag = st_r.start;
	assign conv_active = st_r.active;
	assign conv_ch = st_r.ch;
	assign ladder_on = st_r.ladder;
	assign irq = st_r.irq;
	assign res_lo = st_r.lo;
	assign res_hi = st_r.hi;

	// tick counter used by the length checks
	logic [7:0] tick_cnt_r;
	always_ff @(posedge ref_clk)
	begin
		if (rst || !st_r.active)
		begin
			tick_cnt_r <= 8'h00;
		end
		else if (tk.tick)
		begin
			tick_cnt_r <= tick_cnt_r + 8'h01;
		end
	end

	sequence s_conv_end;
		$fell(st_r.active) && st_r.state == acs_pkg::ACS_DONE;
	endsequence

	property p_len;
		@(posedge ref_clk) disable iff (rst)
		s_conv_end |-> tick_cnt_r == {2'h0, conv_len(st_r.res10, st_r.sh)};
	endproperty
	a_len: assert property (p_len) else $error("conversion length wrong");

	property p_len_sh;
		@(posedge ref_clk) disable iff (rst)
		(s_conv_end and st_r.sh && !st_r.res10) |-> tick_cnt_r == {2'h0, acs_pkg::CYC_8B_SH};
	endproperty
	a_len_sh: assert property (p_len_sh) else $error("hold 8-bit length wrong");

	property p_start_edge;
		@(posedge ref_clk) disable iff (rst)
		$rose(st_r.active) && $past(st_r.state) == acs_pkg::ACS_IDLE |-> $past(!st_r.start && ladder_connect);
	endproperty
	a_start_edge: assert property (p_start_edge) else $error("start without 0->1 or ladder");

	property p_oneshot_irq;
		@(posedge ref_clk) disable iff (rst)
		(st_r.state == acs_pkg::ACS_DONE && mode == acs_pkg::MODE_ONE_SHOT) |=> irq && !start_flag;
	endproperty
	a_oneshot_irq: assert property (p_oneshot_irq) else $error("one-shot end without irq or clear");

	property p_repeat_noirq;
		@(posedge ref_clk) disable iff (rst)
		(st_r.state == acs_pkg::ACS_DONE && mode == acs_pkg::MODE_REPEAT) |=> !irq;
	endproperty
	a_repeat_noirq: assert property (p_repeat_noirq) else $error("repeat raised irq");

	property p_write_lo;
		@(posedge ref_clk) disable iff (rst)
		(st_r.state == acs_pkg::ACS_DONE && st_r.res10) |=> res_lo[8*$past(st_r.ch) +: 8] == $past(sar_result[7:0]);
	endproperty
	a_write_lo: assert property (p_write_lo) else $error("low byte not stored");

	property p_abandon;
		@(posedge ref_clk) disable iff (rst)
		(st_r.state == acs_pkg::ACS_CONV && start_wr && !start_wdata) |=> !conv_active && $stable(res_lo) && $stable(res_hi);
	endproperty
	a_abandon: assert property (p_abandon) else $error("abandon changed results");

	property p_ch_held;
		@(posedge ref_clk) disable iff (rst)
		st_r.active && $past(st_r.active) |-> $stable(st_r.ch);
	endproperty
	a_ch_held: assert property (p_ch_held) else $error("channel changed mid conversion");
endmodule : acs_seq

// *** verif/acs_core_model.sv ***
// acs_core_model: behavioural comparator core beside the sequencer
// assumes the bench sets next_val a few cycles before each start
`timescale 1ns/100ps
module acs_core_model
(
	input wire logic ref_clk,
	input wire logic conv_active,
	input wire logic [9:0] next_val,
	output logic [9:0] sar_result
);
	logic [9:0] val_r;
	logic hold_r;
	always @(posedge ref_clk)
	begin
		hold_r <= conv_active;
		if (!conv_active && !hold_r)
			val_r <= next_val;
	end
	// no valid value outside a conversion and its hold cycle, so show the inverse
	assign sar_result = (conv_active || hold_r) ? val_r : ~val_r;
endmodule : acs_core_model

// *** verif/tb.sv ***
// tb: random and corner-case bench for acs_seq
// assumes acs_core_model answers on sar_result
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic start_wr = 1'b0, start_wdata = 1'b0, res_10b = 1'b0, sh_en = 1'b0, ladder_connect = 1'b0;
	logic [2:0] mode = 3'h0, ch_sel = 3'h0, conv_ch;
	logic [1:0] div_sel = 2'h0;
	logic [9:0] sar_result, next_val = 10'h000;
	logic start_flag, conv_active, ladder_on, irq;
	logic [63:0] res_lo, res_hi, lo_exp = 64'h0, hi_exp = 64'h0;
	logic [31:0] lfsr = 32'h6afc;
	int error_cnt = 0, cmp_count = 0, act_n = 0, irq_n = 0, ends_n = 0;
	always #12.5 ref_clk = ~ref_clk;
	acs_seq dut (.ref_clk(ref_clk), .rst(rst), .start_wr(start_wr), .start_wdata(start_wdata), .mode(mode),
		.ch_sel(ch_sel), .res_10b(res_10b), .sh_en(sh_en), .div_sel(div_sel), .ladder_connect(ladder_connect),
		.sar_result(sar_result), .start_flag(start_flag), .conv_active(conv_active), .conv_ch(conv_ch),
		.ladder_on(ladder_on), .irq(irq), .res_lo(res_lo), .res_hi(res_hi));
	acs_core_model core (.ref_clk(ref_clk), .conv_active(conv_active), .next_val(next_val), .sar_result(sar_result));
	always @(posedge ref_clk)
	begin
		act_n <= act_n + int'(conv_active);
		irq_n <= irq_n + int'(irq);
		ends_n <= ends_n + int'($fell(conv_active));
	end
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : step
	function automatic int cyc(input logic r10, input logic sh);
		return sh ? (r10 ? 33 : 28) : (r10 ? 59 : 49);
	endfunction : cyc
	task automatic wr_start(input logic v);
		start_wr <= 1'b1;
		start_wdata <= v;
		@(posedge ref_clk);
		start_wr <= 1'b0;
	endtask : wr_start
	task automatic conv(input logic [2:0] m, input logic r10, input logic sh, input logic [1:0] dv,
		input logic lad, input logic ab);
		int a0, i0, e0, n, d, act;
		logic go;
		logic [2:0] ch;
		lfsr = step(lfsr);
		ch = lfsr[12:10];
		go = lad && (m <= acs_pkg::MODE_REPEAT);
		n = cyc(r10, sh);
		d = (dv == acs_pkg::DIV_1) ? 1 : 2 * int'(dv);
		@(posedge ref_clk);
		mode <= m;
		ch_sel <= ch;
		res_10b <= r10;
		sh_en <= sh;
		div_sel <= dv;
		ladder_connect <= lad;
		next_val <= lfsr[9:0];
		repeat (3) @(posedge ref_clk);
		`CHK("ladder_on", lad, ladder_on)
		a0 = act_n;
		i0 = irq_n;
		e0 = ends_n;
		wr_start(1'b1);
		repeat (3) @(posedge ref_clk);
		`CHK("conv_active", go, conv_active)
		if (go)
			`CHK("conv_ch", ch, conv_ch)
		repeat (ab ? 1 : (m == acs_pkg::MODE_REPEAT ? 5 * n * d / 2 : n * d + 8)) @(posedge ref_clk);
		wr_start(1'b0);
		repeat (n * d + 8) @(posedge ref_clk);
		act = act_n - a0;
		`CHK("stopped", 1'b0, conv_active)
		`CHK("start_flag", 1'b0, start_flag)
		`CHK("irq_cnt", int'(go && !ab && m == acs_pkg::MODE_ONE_SHOT), irq_n - i0)
		if (m == acs_pkg::MODE_REPEAT && go && !ab)
			`CHK("repeats", 1'b1, ends_n - e0 >= 2)
		else
			`CHK("ends", int'(go), ends_n - e0)
		if (go && !ab && m == acs_pkg::MODE_ONE_SHOT)
			`CHK("act_len", 1'b1, act >= n * d - d + 1 && act <= n * d + 2)
		if (go && !ab)
		begin
			lo_exp[8*ch+:8] = r10 ? lfsr[7:0] : lfsr[9:2];
			hi_exp[8*ch+:8] = r10 ? {6'h0, lfsr[9:8]} : 8'h00;
		end
		`CHK("res_lo", lo_exp, res_lo)
		`CHK("res_hi", hi_exp, res_hi)
	endtask : conv
	task automatic end_of_test;
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	initial
	begin
		#2500000;
		error_cnt++;
		end_of_test();
	end
	initial
	begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		`CHK("rst_lo", 64'h0, res_lo)
		for (int k = 0; k < 12; k++)
			conv(acs_pkg::MODE_ONE_SHOT, k[0], k[1], 2'(k / 4), 1'b1, 1'b0);
		conv(acs_pkg::MODE_REPEAT, 1'b1, 1'b0, acs_pkg::DIV_1, 1'b1, 1'b0);
		conv(acs_pkg::MODE_REPEAT, 1'b0, 1'b1, acs_pkg::DIV_2, 1'b1, 1'b0);
		conv(acs_pkg::MODE_ONE_SHOT, 1'b1, 1'b0, acs_pkg::DIV_4, 1'b1, 1'b1);
		conv(acs_pkg::MODE_REPEAT, 1'b0, 1'b0, acs_pkg::DIV_2, 1'b1, 1'b1);
		conv(acs_pkg::MODE_ONE_SHOT, 1'b0, 1'b0, acs_pkg::DIV_1, 1'b0, 1'b0);
		for (int m = 2; m < 5; m++)
			conv(3'(m), 1'b1, 1'b1, acs_pkg::DIV_1, 1'b1, 1'b0);
		for (int k = 0; k < 8; k++)
			conv(acs_pkg::MODE_ONE_SHOT, lfsr[0], lfsr[1], 2'(lfsr[3:2] % 3), 1'b1, 1'b0);
		end_of_test();
	end
endmodule : tb
